// [src/scc_defines.vh]
// constants for the converter clock and sleep control block
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// register byte offsets
`define SCC_CTRL_OFS 8'h00
`define SCC_TIMING_OFS 8'h04
`define SCC_STATUS_OFS 8'h08
`define SCC_IRQ_STAT_OFS 8'h0C
`define SCC_IRQ_MASK_OFS 8'h10
`define SCC_RESULT_OFS 8'h14

// control fields
`define SCC_CTRL_ON_BIT 0
`define SCC_CTRL_AUTO_BIT 1
`define SCC_CTRL_RC_BIT 2
`define SCC_CTRL_SAMP_BIT 3
`define SCC_CTRL_TRIG_LSB 4
`define SCC_CTRL_SPI_LSB 8

// timing fields
`define SCC_TIM_DIV_LSB 0
`define SCC_TIM_ACQ_LSB 8

// encodings and counts
`define SCC_TRIG_AUTO 3'b111
`define SCC_CONVERT_IN_PROGRESS_PERIODS 5'h0E
`define SCC_ACQ_RESET 5'h01
`define SCC_DIV_RESET 6'h13

// status bits
`define SCC_ST_CONVERT_IN_PROGRESS_BIT 0
`define SCC_ST_SAMP_BIT 1
`define SCC_ST_SHUT_BIT 2

// interrupt status bits
`define SCC_IRQ_DONE_BIT 0
`define SCC_IRQ_ABORT_BIT 1

`endif

// [src/scc_tick_div.v]
// half-instruction-cycle tick divider producing conversion clock enables
`timescale 1ns/1ps
`include "scc_defines.vh"

module scc_tick_div #(
    parameter W = 6
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire run_i,
    input wire half_tick_i,
    input wire [W-1:0] divisor_i,
    output reg tick_o
);
    reg [W-1:0] cnt_reg;

    // period = (divisor + 1) half instruction cycles
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= {W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (!run_i) begin
                cnt_reg <= {W{1'b0}};
            end else if (half_tick_i) begin
                if (cnt_reg >= divisor_i) begin
                    cnt_reg <= {W{1'b0}};
                    tick_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// [src/scc_clk_sel.v]
// glitch-free choice between divided and rc conversion ticks
`timescale 1ns/1ps

module scc_clk_sel (
    input wire core_clk_i,
    input wire rst_i,
    input wire sel_rc_i,
    input wire stop_i,
    input wire div_tick_i,
    input wire rc_tick_i,
    output reg tick_o,
    output reg rc_active_o
);
    reg src_rc_reg;

    // source changes only between ticks, so no tick is split or doubled
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_rc_reg <= 1'b0;
            tick_o <= 1'b0;
            rc_active_o <= 1'b0;
        end else begin
            if (!(div_tick_i || rc_tick_i)) begin
                src_rc_reg <= sel_rc_i;
            end
            rc_active_o <= src_rc_reg;
            tick_o <= !stop_i && (src_rc_reg ? rc_tick_i : div_tick_i);
        end
    end
endmodule

// [src/scc_top.v]
// converter clock, sampling sequence and sleep control with axi4-lite registers
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "scc_defines.vh"

module scc_top #(
    parameter DIV_W = 6,
    parameter ACQ_W = 5,
    parameter SPI_W = 4,
    parameter RES_W = 12,
    parameter INSTR_HALF = 1,
    parameter RC_DIV = 8
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire sleep_i,
    input wire [RES_W-1:0] sar_result_i,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg convert_in_progress_clk_o,
    output reg sample_o,
    output reg convert_in_progress_o,
    output reg wake_o,
    output reg irq_o
);
    localparam ST_OFF = 2'd0;
    localparam ST_ACQ = 2'd1;
    localparam ST_CONVERT_IN_PROGRESS = 2'd2;
    localparam ST_WAIT = 2'd3;

    // control state
    reg module_on_reg;
    reg auto_sample_en_reg;
    reg rc_clock_sel_reg;
    reg samp_reg;
    reg [2:0] trigger_source_sel_reg;
    reg [SPI_W-1:0] samples_per_irq_reg;
    reg [DIV_W-1:0] convert_in_progress_clk_divisor_reg;
    reg [ACQ_W-1:0] acquire_length_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg [RES_W-1:0] result_buffer_reg;
    reg [1:0] state_reg;
    reg [4:0] per_cnt_reg;
    reg [SPI_W-1:0] smp_cnt_reg;
    reg shut_reg;
    reg delay_reg;
    reg [7:0] half_cnt_reg;
    reg half_tick_reg;
    reg [7:0] rc_cnt_reg;
    reg rc_tick_reg;
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [31:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire div_tick;
    wire tad_tick;
    wire rc_active;
    wire active;
    wire wr_go;
    wire [7:0] wofs;
    wire [7:0] rofs;

    // off, or self-shut after sleep conversion, stops the conversion clock and the sequencer
    assign active = module_on_reg && !shut_reg;
    // in sleep only the rc source keeps ticking
    assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wofs = awaddr_reg[7:0];
    assign rofs = s_axi_araddr[7:0];

    // instruction-clock half cycle enables, stopped in sleep, and rc ticks, which keep running in sleep
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_cnt_reg <= 8'h00;
            half_tick_reg <= 1'b0;
            rc_cnt_reg <= 8'h00;
            rc_tick_reg <= 1'b0;
        end else begin
            half_tick_reg <= 1'b0;
            rc_tick_reg <= 1'b0;
            if (sleep_i) begin
                half_cnt_reg <= 8'h00;
            end else if (half_cnt_reg >= INSTR_HALF[7:0] - 8'h01) begin
                half_cnt_reg <= 8'h00;
                half_tick_reg <= 1'b1;
            end else begin
                half_cnt_reg <= half_cnt_reg + 8'h01;
            end
            if (rc_cnt_reg >= RC_DIV[7:0] - 8'h01) begin
                rc_cnt_reg <= 8'h00;
                rc_tick_reg <= 1'b1;
            end else begin
                rc_cnt_reg <= rc_cnt_reg + 8'h01;
            end
        end
    end

    scc_tick_div #(
        .W(DIV_W)
    ) u_div (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(active && !sleep_i),
        .half_tick_i(half_tick_reg),
        .divisor_i(convert_in_progress_clk_divisor_reg),
        .tick_o(div_tick)
    );

    scc_clk_sel u_sel (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .sel_rc_i(rc_clock_sel_reg),
        .stop_i(!active || (sleep_i && !rc_clock_sel_reg)),
        .div_tick_i(div_tick),
        .rc_tick_i(rc_tick_reg),
        .tick_o(tad_tick),
        .rc_active_o(rc_active)
    );

    // sequencer; aborts win over any auto-start in the same cycle
    reg [1:0] ev_reg;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_OFF;
            per_cnt_reg <= 5'h00;
            smp_cnt_reg <= {SPI_W{1'b0}};
            result_buffer_reg <= {RES_W{1'b0}};
            convert_in_progress_o <= 1'b0;
            sample_o <= 1'b0;
            ev_reg <= 2'b00;
            delay_reg <= 1'b0;
            shut_reg <= 1'b0;
            wake_o <= 1'b0;
            convert_in_progress_clk_o <= 1'b0;
        end else begin
            ev_reg <= 2'b00;
            wake_o <= 1'b0;
            convert_in_progress_clk_o <= tad_tick;
            if (!module_on_reg) begin
                shut_reg <= 1'b0;
            end
            if (!active || (sleep_i && !rc_active && state_reg == ST_CONVERT_IN_PROGRESS)) begin
                if (state_reg == ST_CONVERT_IN_PROGRESS) begin
                    ev_reg[`SCC_IRQ_ABORT_BIT] <= 1'b1;
                end
                state_reg <= ST_OFF;
                convert_in_progress_o <= 1'b0;
                sample_o <= 1'b0;
                if (!active) begin
                    smp_cnt_reg <= {SPI_W{1'b0}};
                end
            end else begin
                case (state_reg)
                    ST_OFF: begin
                        if ((samp_reg || auto_sample_en_reg) && !sleep_i) begin
                            state_reg <= ST_ACQ;
                            per_cnt_reg <= 5'h00;
                            sample_o <= 1'b1;
                        end
                    end
                    ST_ACQ: begin
                        if (tad_tick) begin
                            per_cnt_reg <= per_cnt_reg + 5'h01;
                        end
                        // start after acquire_length whole periods
                        if (trigger_source_sel_reg == `SCC_TRIG_AUTO && tad_tick &&
                            per_cnt_reg + 5'h01 >= acquire_length_reg) begin
                            sample_o <= 1'b0;
                            per_cnt_reg <= 5'h00;
                            delay_reg <= rc_active;
                            state_reg <= rc_active ? ST_WAIT : ST_CONVERT_IN_PROGRESS;
                            convert_in_progress_o <= !rc_active;
                        end else if (trigger_source_sel_reg != `SCC_TRIG_AUTO &&
                                     !samp_reg) begin
                            sample_o <= 1'b0;
                            per_cnt_reg <= 5'h00;
                            state_reg <= rc_active ? ST_WAIT : ST_CONVERT_IN_PROGRESS;
                            convert_in_progress_o <= !rc_active;
                        end
                    end
                    ST_WAIT: begin
                        // one instruction cycle after an auto-trigger start, half of one after a samp_reg start, lets the core enter sleep quietly
                        if (half_tick_reg || sleep_i) begin
                            delay_reg <= 1'b0;
                            if (!delay_reg) begin
                                state_reg <= ST_CONVERT_IN_PROGRESS;
                                convert_in_progress_o <= 1'b1;
                            end
                        end
                    end
                    ST_CONVERT_IN_PROGRESS: begin
                        if (tad_tick) begin
                            per_cnt_reg <= per_cnt_reg + 5'h01;
                            if (per_cnt_reg == `SCC_CONVERT_IN_PROGRESS_PERIODS - 5'h01) begin
                                convert_in_progress_o <= 1'b0;
                                result_buffer_reg <= sar_result_i;
                                per_cnt_reg <= 5'h00;
                                if (smp_cnt_reg >= samples_per_irq_reg) begin
                                    smp_cnt_reg <= {SPI_W{1'b0}};
                                    ev_reg[`SCC_IRQ_DONE_BIT] <= 1'b1;
                                    if (sleep_i && irq_mask_reg[`SCC_IRQ_DONE_BIT]) begin
                                        wake_o <= 1'b1;
                                    end
                                end else begin
                                    smp_cnt_reg <= smp_cnt_reg + {{(SPI_W-1){1'b0}}, 1'b1};
                                end
                                if (sleep_i && !irq_mask_reg[`SCC_IRQ_DONE_BIT]) begin
                                    shut_reg <= 1'b1;
                                    state_reg <= ST_OFF;
                                end else if (auto_sample_en_reg) begin
                                    state_reg <= ST_ACQ;
                                    sample_o <= 1'b1;
                                end else begin
                                    state_reg <= ST_OFF;
                                end
                            end
                        end
                    end
                    default: state_reg <= ST_OFF;
                endcase
            end
        end
    end

    // axi4-lite slave and registers; sleep leaves the control, timing and mask registers alone
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            module_on_reg <= 1'b0;
            auto_sample_en_reg <= 1'b0;
            rc_clock_sel_reg <= 1'b0;
            samp_reg <= 1'b0;
            trigger_source_sel_reg <= 3'b000;
            samples_per_irq_reg <= {SPI_W{1'b0}};
            convert_in_progress_clk_divisor_reg <= `SCC_DIV_RESET;
            acquire_length_reg <= `SCC_ACQ_RESET;
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
            irq_o <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            if (s_axi_awvalid && !aw_hold_reg && !s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !w_hold_reg && !s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // hardware events win over a same-cycle clear
            irq_stat_reg <= irq_stat_reg | ev_reg;
            if (wr_go) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                case (wofs)
                    `SCC_CTRL_OFS: begin
                        if (wstrb_reg[0]) begin
                            module_on_reg <= wdata_reg[`SCC_CTRL_ON_BIT];
                            auto_sample_en_reg <= wdata_reg[`SCC_CTRL_AUTO_BIT];
                            rc_clock_sel_reg <= wdata_reg[`SCC_CTRL_RC_BIT];
                            samp_reg <= wdata_reg[`SCC_CTRL_SAMP_BIT];
                            trigger_source_sel_reg <= wdata_reg[`SCC_CTRL_TRIG_LSB +: 3];
                        end
                        if (wstrb_reg[1]) begin
                            samples_per_irq_reg <= wdata_reg[`SCC_CTRL_SPI_LSB +: SPI_W];
                        end
                    end
                    `SCC_TIMING_OFS: begin
                        if (wstrb_reg[0]) begin
                            convert_in_progress_clk_divisor_reg <= wdata_reg[`SCC_TIM_DIV_LSB +: DIV_W];
                        end
                        if (wstrb_reg[1]) begin
                            acquire_length_reg <= wdata_reg[`SCC_TIM_ACQ_LSB +: ACQ_W];
                        end
                    end
                    `SCC_IRQ_STAT_OFS: begin
                        if (wstrb_reg[0]) begin
                            irq_stat_reg <= (irq_stat_reg & ~wdata_reg[1:0]) | ev_reg;
                        end
                    end
                    `SCC_IRQ_MASK_OFS: begin
                        if (wstrb_reg[0]) begin
                            irq_mask_reg <= wdata_reg[1:0];
                        end
                    end
                    `SCC_STATUS_OFS, `SCC_RESULT_OFS: s_axi_bresp <= 2'b00;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
            irq_o <= |(irq_stat_reg & irq_mask_reg);
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (rofs)
                    `SCC_CTRL_OFS: s_axi_rdata <= {20'h0_0000, samples_per_irq_reg,
                        1'b0, trigger_source_sel_reg, samp_reg, rc_clock_sel_reg,
                        auto_sample_en_reg, module_on_reg};
                    `SCC_TIMING_OFS: s_axi_rdata <= {19'h0_0000, acquire_length_reg,
                        2'b00, convert_in_progress_clk_divisor_reg};
                    `SCC_STATUS_OFS: s_axi_rdata <= {29'h0000_0000, shut_reg,
                        sample_o, convert_in_progress_o};
                    `SCC_IRQ_STAT_OFS: s_axi_rdata <= {30'h0000_0000, irq_stat_reg};
                    `SCC_IRQ_MASK_OFS: s_axi_rdata <= {30'h0000_0000, irq_mask_reg};
                    `SCC_RESULT_OFS: s_axi_rdata <= {20'h0_0000, result_buffer_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end
endmodule

// [verif/scc_top_sva.sv]
// assertion checker for the converter clock and sleep control block
`timescale 1ns/1ps
module scc_top_sva (
    input wire core_clk_i,
    input wire rst_i,
    input wire sleep_i,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire convert_in_progress_clk_o,
    input wire sample_o,
    input wire convert_in_progress_o,
    input wire wake_o
);
    reg [7:0] a_reg;
    reg [31:0] d_reg;
    reg bv_reg;
    reg on_reg;
    reg rc_reg;
    // shadow trails the real register, so checks below wait a cycle more
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_reg <= 8'h00;
            d_reg <= 32'h0000_0000;
            bv_reg <= 1'b0;
            on_reg <= 1'b0;
            rc_reg <= 1'b0;
        end else begin
            bv_reg <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
                a_reg <= s_axi_awaddr[7:0];
            if (s_axi_wvalid && s_axi_wready)
                d_reg <= s_axi_wdata;
            if (s_axi_bvalid && !bv_reg && s_axi_bresp == 2'b00 && a_reg == 8'h00) begin
                on_reg <= d_reg[0];
                rc_reg <= d_reg[2];
            end
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    property p_rd_lat;
        s_axi_arvalid && !$past(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer not one cycle late");
    property p_wr_lat;
        $rose(s_axi_awvalid && s_axi_wvalid) |-> ##[1:4] s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response missing");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read response repeated");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read with data");
    property p_wake;
        wake_o |-> $past(sleep_i) ##1 !wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake pulse outside sleep");
    property p_excl;
        !(sample_o && convert_in_progress_o);
    endproperty
    a_excl: assert property (p_excl) else $error("sampling during conversion");
    property p_off_quiet;
        !on_reg && !$past(on_reg) |-> !convert_in_progress_clk_o && !sample_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("activity while off");
    property p_sleep_quiet;
        sleep_i && $past(sleep_i) && $past(sleep_i, 2) && !rc_reg |-> !convert_in_progress_clk_o;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("clock in sleep");
endmodule
bind scc_top scc_top_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .sleep_i(sleep_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .convert_in_progress_clk_o(convert_in_progress_clk_o), .sample_o(sample_o),
    .convert_in_progress_o(convert_in_progress_o), .wake_o(wake_o));

// [verif/scc_top_bench.sv]
// self-checking bench for the converter clock and sleep control block
`timescale 1ns/1ps
`include "scc_defines.vh"
module scc_top_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg slp = 1'b0;
    reg [11:0] res = 12'h000;
    reg [31:0] awa = 32'h0000_0000;
    reg [31:0] wd = 32'h0000_0000;
    reg [31:0] ara = 32'h0000_0000;
    reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    wire awr, wrdy, bv, arr, rv, cclk, smp, cip, wk, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rd;
    integer miscompares = 0, samples_checked = 0;
    integer n, p, d, a, s, i;
    reg [31:0] v;
    reg [1:0] q;
    always #12.5 clk = ~clk;
    scc_top uut (.core_clk_i(clk), .rst_i(rst), .sleep_i(slp), .sar_result_i(res),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .convert_in_progress_clk_o(cclk), .sample_o(smp), .convert_in_progress_o(cip),
        .wake_o(wk), .irq_o(irq));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task axw(input [31:0] ad, input [31:0] dt);
        begin
            awa <= ad;
            wd <= dt;
            awv <= 1'b1;
            wv <= 1'b1;
            br <= 1'b1;
            @(posedge clk);
            while (br) begin
                if (awr)
                    awv <= 1'b0;
                if (wrdy)
                    wv <= 1'b0;
                if (bv) begin
                    br <= 1'b0;
                    chk(bresp, 0);
                end
                @(posedge clk);
            end
        end
    endtask
    task axr(input [31:0] ad, input [31:0] ex, input [1:0] er);
        begin
            ara <= ad;
            arv <= 1'b1;
            rr <= 1'b1;
            @(posedge clk);
            while (rr) begin
                if (arr)
                    arv <= 1'b0;
                if (rv) begin
                    rr <= 1'b0;
                    v = rd;
                    q = rresp;
                end
                @(posedge clk);
            end
            chk(q, er);
            if (ex != 32'hffff_ffff)
                chk(v, ex);
        end
    endtask
    function sg(input integer k);
        case (k)
            0: sg = cclk;
            1: sg = smp;
            2: sg = cip;
            3: sg = irq;
            default: sg = wk;
        endcase
    endfunction
    // edges until the signal changes to v1, at most 5000; a level already there waits
    task wt(input integer k, input v1, output integer c);
        reg pv;
        begin
            c = 0;
            do begin
                pv = sg(k);
                @(posedge clk);
                c = c + 1;
            end while (!(sg(k) === v1 && pv !== v1) && c < 5000);
            if (c >= 5000)
                chk(c, 0);
        end
    endtask
    initial begin
        #(40000 * 25);
        miscompares = miscompares + 1;
        close_out;
    end
    initial begin
        v = $urandom(32'h09ac_0471);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axr(`SCC_TIMING_OFS, 32'h0000_0113, 2'b00);
        axr(`SCC_CTRL_OFS, 32'h0000_0000, 2'b00);
        axr(32'h0000_0040, 32'h0000_0000, 2'b10);
        $display("test reset values done");
        d = 13 + $urandom % 8;
        a = 1 + $urandom % 4;
        s = $urandom % 4;
        p = d + 1;
        v = $urandom;
        res <= v[11:0];
        axw(`SCC_TIMING_OFS, (a << 8) | d);
        axw(`SCC_IRQ_MASK_OFS, 32'h0000_0001);
        axw(`SCC_CTRL_OFS, 32'h0000_0072 | (s << 8));
        axw(`SCC_CTRL_OFS, 32'h0000_0073 | (s << 8));
        i = 0;
        do begin
            wt(2, 1, n);
            wt(2, 0, n);
            i = i + 1;
            repeat (2) @(posedge clk);
        end while (irq !== 1'b1 && i < 20);
        chk(i, s + 1);
        axw(`SCC_IRQ_MASK_OFS, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        wt(0, 1, n);
        wt(0, 1, n);
        chk(n, p);
        wt(1, 1, n);
        wt(1, 0, n);
        chk(n, a * p);
        chk(cip, 1);
        wt(2, 0, n);
        chk(n, 14 * p);
        wt(1, 1, n);
        wt(1, 1, n);
        chk(n, (a + 14) * p);
        axr(`SCC_RESULT_OFS, res, 2'b00);
        $display("test auto sequence done");
        s = res;
        v = $urandom;
        res <= res ^ (v[11:0] | 12'h001);
        wt(2, 1, n);
        repeat (3) @(posedge clk);
        slp <= 1'b1;
        repeat (6) @(posedge clk);
        chk(cip, 0);
        axr(`SCC_RESULT_OFS, s, 2'b00);
        axr(`SCC_TIMING_OFS, (a << 8) | d, 2'b00);
        axr(`SCC_IRQ_STAT_OFS, 32'hffff_ffff, 2'b00);
        chk(v[1], 1);
        repeat (100) @(posedge clk);
        slp <= 1'b0;
        axw(`SCC_CTRL_OFS, 32'h0000_0000);
        axw(`SCC_IRQ_MASK_OFS, 32'h0000_0003);
        axw(`SCC_IRQ_STAT_OFS, 32'h0000_0003);
        repeat (300) @(posedge clk);
        chk({irq, smp, cip}, 0);
        $display("test sleep abort done");
        for (i = 0; i < 2; i = i + 1) begin
            v = $urandom;
            res <= v[11:0];
            axw(`SCC_IRQ_MASK_OFS, 1 - i);
            axw(`SCC_CTRL_OFS, 32'h0000_0077);
            slp <= 1'b1;
            wt(2, 1, n);
            wt(2, 0, n);
            chk(wk, 1 - i);
            if (i == 0)
                wt(4, 1, n);
            chk(n < 5000, 1);
            repeat (300) @(posedge clk);
            if (i == 0)
                chk(irq, 1);
            else
                chk(cip, 0);
            axr(`SCC_RESULT_OFS, res, 2'b00);
            axr(`SCC_CTRL_OFS, 32'h0000_0077, 2'b00);
            axr(`SCC_STATUS_OFS, 32'hffff_ffff, 2'b00);
            chk(v[2], i);
            slp <= 1'b0;
            axw(`SCC_CTRL_OFS, 32'h0000_0000);
            axw(`SCC_IRQ_STAT_OFS, 32'h0000_0003);
        end
        axr(`SCC_STATUS_OFS, 32'h0000_0000, 2'b00);
        $display("test rc sleep done");
        close_out;
    end
endmodule
